// ===== common/adcop_pkg.sv
/*
  Constants for the converter output port: word width, pipeline latency,
  power-up invalid interval and code landmarks.
  Assumes a single 25 MHz system clock that stands in for the sample clock.
*/
package adcop_pkg;
  localparam int CODE_W = 10;
  localparam int MSB_POS = 9;
  localparam int PIPE_LAT = 7;
  localparam int INIT_CYC = 20;
  localparam int CNT_W = 5;
  localparam logic [CODE_W-1:0] CODE_ZERO = 10'h000;
  localparam logic [CODE_W-1:0] CODE_MID_LO = 10'h1FF;
  localparam logic [CODE_W-1:0] CODE_MID_HI = 10'h200;
  localparam logic [CODE_W-1:0] CODE_FULL = 10'h3FF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  // Core clock period; the device needs a rate above 1 MSPS
  localparam int CLK_PERIOD_NS = 40;
  localparam int MIN_RATE_KSPS = 1000;
endpackage

// ===== design/adcop_delay.sv
/*
  Fixed-length word delay line built from flip-flops.
  Assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adcop_delay #(
  parameter int W = 10,
  parameter int N = 7
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage_r [N];

  always_ff @(posedge clk) begin
    if (rst) begin
      stage_r[0] <= '0;
    end else begin
      stage_r[0] <= din;
    end
  end

  genvar g;
  generate
    for (g = 1; g < N; g++) begin : g_stage
      always_ff @(posedge clk) begin
        if (rst) begin
          stage_r[g] <= '0;
        end else begin
          stage_r[g] <= stage_r[g-1];
        end
      end
    end
  endgenerate

  assign dout = stage_r[N-1];
endmodule
`default_nettype wire

// ===== design/adcop_port.sv
/*
  Digital output side of a 10-bit pipelined converter: takes a sample on
  each falling edge of the sample clock, delays it through the pipeline,
  formats it and drives the parallel output word with a valid qualifier.
  Assumes the capture logic runs on the same clock and the quantised input
  word SAMPLE_CODE is produced by the analog model on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Falling clock edge samples the analog input.
// - Word appears seven cycles after its sample.
// - Afterwards one new word every clock.
// - Words invalid during first twenty clocks.
// - Format low gives offset binary, 0..1023.
// - Format high inverts MSB: two's complement.
// - Codes span 0 to 1023 offset binary.
// - Output word retimed through two latch stages.
module adcop_port #(
  parameter int LATENCY = adcop_pkg::PIPE_LAT,
  parameter int INIT_CYCLES = adcop_pkg::INIT_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [adcop_pkg::CODE_W-1:0] SAMPLE_CODE,
  input wire logic OUTPUT_FORMAT_SELECT,
  output logic [adcop_pkg::CODE_W-1:0] OUTPUT_CODE_BITS,
  output logic OUTPUT_VALID
);
  import adcop_pkg::*;

  // Core stages and the two output latches together make up the full latency
  localparam int CORE_LAT = LATENCY - 2;
  localparam int WARM_CYC = (INIT_CYCLES > LATENCY) ? INIT_CYCLES : LATENCY;

  logic [CODE_W-1:0] sample_r;
  logic [CODE_W-1:0] core_out;
  logic [CODE_W-1:0] hold_r;
  logic [CODE_W-1:0] word_r;
  logic fmt_s1_r, fmt_s2_r, fmt_s3_r, fmt_r;
  logic [CNT_W-1:0] warm_r;
  logic [CNT_W-1:0] warm_nxt;
  logic valid_r;
  logic [LATENCY-1:0] vpipe_r;

  function automatic logic [CODE_W-1:0] fmt_code(input logic [CODE_W-1:0] ob, input logic twos);
    logic [CODE_W-1:0] res;
    res = ob;
    if (twos) begin
      res[MSB_POS] = ~ob[MSB_POS];
    end
    return res;
  endfunction

  // Sample taken on the falling edge, as the device does
  always_ff @(negedge CLK) begin
    if (RST) begin
      sample_r <= CODE_ZERO;
    end else begin
      sample_r <= SAMPLE_CODE;
    end
  end

  adcop_delay #(
    .W(CODE_W),
    .N(CORE_LAT)
  ) u_core (
    .clk(CLK),
    .rst(RST),
    .din(sample_r),
    .dout(core_out)
  );

  // Format pin is static but asynchronous: three stages, change once 2 and 3 agree
  always_ff @(posedge CLK) begin
    if (RST) begin
      fmt_s1_r <= 1'b0;
      fmt_s2_r <= 1'b0;
      fmt_s3_r <= 1'b0;
      fmt_r <= 1'b0;
    end else begin
      fmt_s1_r <= OUTPUT_FORMAT_SELECT;
      fmt_s2_r <= fmt_s1_r;
      fmt_s3_r <= fmt_s2_r;
      if (fmt_s2_r == fmt_s3_r) begin
        fmt_r <= fmt_s3_r;
      end
    end
  end

  // Double buffered output latching
  always_ff @(posedge CLK) begin
    if (RST) begin
      hold_r <= CODE_ZERO;
      word_r <= CODE_ZERO;
    end else begin
      hold_r <= core_out;
      word_r <= fmt_code(hold_r, fmt_r);
    end
  end

  assign OUTPUT_CODE_BITS = word_r;

  // Power-up interval counter; valid also waits for the pipeline to fill
  // Terminal count of the warm-up counter; the counter parks there, so it
  // never wraps and valid cannot drop again without a reset
  function automatic logic [CNT_W-1:0] warm_max();
    return CNT_W'(WARM_CYC);
  endfunction

  always_comb begin
    warm_nxt = warm_r;
    if (warm_r != warm_max()) begin
      warm_nxt = warm_r + CNT_ONE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      warm_r <= CNT_ZERO;
    end else begin
      warm_r <= warm_nxt;
    end
  end

  // Fill marker: bit k is set once k+1 rising edges have passed since reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      vpipe_r <= '0;
    end else begin
      vpipe_r <= {vpipe_r[LATENCY-2:0], 1'b1};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= (warm_nxt == warm_max()) && vpipe_r[LATENCY-2];
    end
  end

  assign OUTPUT_VALID = valid_r;

  // Assertions
  a_fmt_msb_only: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> OUTPUT_CODE_BITS[MSB_POS-1:0] == $past(hold_r[MSB_POS-1:0]))
    else $error("Output low bits differ from latched word");

  a_twos_msb: assert property (@(posedge CLK) disable iff (RST)
    fmt_r |=> OUTPUT_CODE_BITS[MSB_POS] == ~$past(hold_r[MSB_POS]))
    else $error("Format select high did not invert MSB");

  a_ob_msb_keep: assert property (@(posedge CLK) disable iff (RST)
    !fmt_r |=> OUTPUT_CODE_BITS[MSB_POS] == $past(hold_r[MSB_POS]))
    else $error("Format select low changed the MSB");

  // Low bits do not depend on the format, so this holds across a format change
  a_pipe_latency: assert property (@(posedge CLK) disable iff (RST)
    vpipe_r[LATENCY-1] |-> OUTPUT_CODE_BITS[MSB_POS-1:0] == $past(sample_r[MSB_POS-1:0], LATENCY))
    else $error("Word did not appear one pipeline latency after its sample");

  a_word_follows: assert property (@(posedge CLK) disable iff (RST)
    (!fmt_r && $past(fmt_r) == 1'b0 && $past(fmt_r, 2) == 1'b0 && vpipe_r[LATENCY-1])
    |-> OUTPUT_CODE_BITS == $past(core_out, 2))
    else $error("Output word not from two cycles earlier");

  a_valid_low_init: assert property (@(posedge CLK) disable iff (RST)
    (warm_r < CNT_W'(INIT_CYCLES - 1)) |-> !OUTPUT_VALID)
    else $error("Valid asserted during power-up interval");

  a_valid_stays: assert property (@(posedge CLK) disable iff (RST)
    OUTPUT_VALID |=> OUTPUT_VALID)
    else $error("Valid dropped after being raised");

  a_valid_rises: assert property (@(posedge CLK) disable iff (RST)
    (warm_r == CNT_W'(WARM_CYC - 1)) |=> OUTPUT_VALID)
    else $error("Valid not raised after warm-up");

  a_hold_stage: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> hold_r == $past(core_out))
    else $error("First output latch did not capture core word");

  // First latch holds the sample one edge before it reaches the pins
  a_latch_pair: assert property (@(posedge CLK) disable iff (RST)
    vpipe_r[LATENCY-2] |-> hold_r == $past(sample_r, LATENCY - 1))
    else $error("Core stages did not carry the sample to the first latch");

  // Sample flop runs on the falling edge, half a cycle ahead of the core
  a_sample_take: assert property (@(negedge CLK) disable iff (RST)
    1'b1 |=> sample_r == $past(SAMPLE_CODE))
    else $error("Falling edge did not take the input word");

  a_valid_after_warm: assert property (@(posedge CLK) disable iff (RST)
    OUTPUT_VALID |-> warm_r == CNT_W'(WARM_CYC))
    else $error("Valid raised before the warm-up count ended");

  a_valid_reset: assert property (@(posedge CLK)
    RST |=> !OUTPUT_VALID)
    else $error("Valid not cleared by reset");

  // A half-settled pin must never reach the output format
  a_fmt_agree: assert property (@(posedge CLK) disable iff (RST)
    (fmt_s2_r != fmt_s3_r) |=> $stable(fmt_r))
    else $error("Format changed before the synchroniser agreed");
endmodule
`default_nettype wire

// ===== bench/adcop_capture.sv
/*
  Capture logic on the far side of the converter output port.
  Assumes it runs on the same sample clock as the port.
*/
`timescale 1ns/1ps
`default_nettype none
module adcop_capture (
  input wire logic clk,
  input wire logic [adcop_pkg::CODE_W-1:0] word,
  input wire logic valid,
  output logic [adcop_pkg::CODE_W-1:0] last_word,
  output int count
);
  import adcop_pkg::*;
  int cnt = 0;
  assign count = cnt;
  // Warm-up words are dropped, never stored
  always @(posedge clk) begin
    if (valid) begin
      last_word <= word;
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/pipelined_adc_output_port_test.sv
/*
  Self-checking bench for the converter output port, with a queue model.
  Assumes the port and its capture partner share one 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pipelined_adc_output_port_test;
  import adcop_pkg::*;
  logic CLK = 0;
  logic RST = 1;
  logic [CODE_W-1:0] SAMPLE_CODE = 10'h000;
  logic OUTPUT_FORMAT_SELECT = 0;
  logic [CODE_W-1:0] OUTPUT_CODE_BITS;
  logic OUTPUT_VALID;
  logic [CODE_W-1:0] got_word;
  int got_cnt;
  int fails = 0;
  int checked = 0;
  int n = 0;
  int fmt_age = 0;
  int last_exp = 0;
  int hist[$];
  int marks[5] = '{0, 511, 512, 1022, 1023};
  // 25 MHz keeps the rate well above the minimum
  always #(CLK_PERIOD_NS/2) CLK = ~CLK;
  adcop_port dut (.CLK(CLK), .RST(RST), .SAMPLE_CODE(SAMPLE_CODE),
    .OUTPUT_FORMAT_SELECT(OUTPUT_FORMAT_SELECT), .OUTPUT_CODE_BITS(OUTPUT_CODE_BITS),
    .OUTPUT_VALID(OUTPUT_VALID));
  adcop_capture cap (.clk(CLK), .word(OUTPUT_CODE_BITS), .valid(OUTPUT_VALID),
    .last_word(got_word), .count(got_cnt));
  task automatic check(string what, logic [CODE_W-1:0] seen, logic [CODE_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One clock: check outputs, then present the next sample
  task automatic step(int c);
    int e;
    @(posedge CLK);
    #1;
    n++;
    // Valid rises with the twentieth rising edge after release
    check("valid", 10'(OUTPUT_VALID), 10'(n >= INIT_CYC));
    if (hist.size() == PIPE_LAT) begin
      e = hist.pop_front() ^ (OUTPUT_FORMAT_SELECT ? 512 : 0);
      // Format pin is synchronised, so skip words in flight across a change
      if (fmt_age > 12 && OUTPUT_VALID === 1'b1) begin
        check("word", OUTPUT_CODE_BITS, e[CODE_W-1:0]);
        last_exp = e;
      end
    end
    fmt_age++;
    SAMPLE_CODE = c[CODE_W-1:0];
    hist.push_back(c);
  endtask
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(10536));
    repeat (20) @(posedge CLK);
    #1 RST = 0;
    for (int f = 0; f < 2; f++) begin
      OUTPUT_FORMAT_SELECT = f[0];
      fmt_age = 0;
      repeat (30) step($urandom_range(1023));
      foreach (marks[i]) step(marks[i]);
      repeat (8) step($urandom_range(1023));
      $display("format %0d test done, checked %0d", f, checked);
    end
    // One more edge lets the partner take the last checked word
    @(posedge CLK);
    #1;
    check("captured count", 10'(got_cnt), 10'(n + 1 - INIT_CYC));
    check("captured word", got_word, 10'(last_exp));
    close_out();
  end
endmodule
`default_nettype wire
